// ==== src/hstc_switch_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none
module hstc_switch_ctrl
   import hstc_pkg::*;
#(
   parameter int TICK_CNT = TICK_CYCLES // Clocks per 0.1 ms tick
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Register port
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wr_data,
   output logic [DATA_W-1:0] reg_rd_data,
   // Sources from neighbouring generators
   input wire logic first_cycle_timer,
   input wire logic first_duty_generator,
   input wire logic second_duty_generator,
   // Chip state
   input wire logic chip_restart_state,
   input wire logic cyclic_sense_active,
   // Supply and switch faults
   input wire logic supply_overvoltage,
   input wire logic supply_undervoltage,
   input wire logic [3:0] switch_overload,
   // Switch drives
   output logic [3:0] switch_output,
   output logic second_cycle_timer
);
   import hstc_pkg::*;

   // Register map, 7-bit index, byte wide:
   //    0x0d second timer: on-time in 6:4, period in 2:0
   //    0x10 shutdown: overvoltage 6, undervoltage 5, recovery 4
   //    0x14 switches one and two, 0x15 switches three and four
   // Unmapped indexes ignore writes and read back zero.

   // Refuse a tick rate the counter logic cannot serve
   if (TICK_CNT < 1 || TICK_CNT > 65535)
   begin : g_bad_tick
      $error("TICK_CNT out of range");
   end

   ////////////////////////////////////////////////////////////////////////
   // Register state
   logic [2:0] cfg_r [4]; // Per-switch mode fields
   logic [2:0] cfg_nxt [4];
   logic [2:0] on_r; // Second timer on-time code
   logic [2:0] on_nxt;
   logic [2:0] per_r; // Second timer period code
   logic [2:0] per_nxt;
   logic ov_dis_r; // Overvoltage shutdown disable
   logic ov_dis_nxt;
   logic uv_dis_r; // Undervoltage shutdown disable
   logic uv_dis_nxt;
   logic recover_r; // Restore after supply fault
   logic recover_nxt;
   logic [DATA_W-1:0] rd_r; // Read data
   logic [DATA_W-1:0] rd_nxt;

   // Derived
   logic supply_cut; // Supply fault active and enabled
   logic tmr2_assigned; // Some switch follows the second timer
   logic [3:0] sw_level; // Decoded switch levels
   logic [3:0] sw_nxt;
   logic [3:0] sw_r;

   // Images come from the stored fields, so reads need no extra storage
   // Pair, timer and shutdown register images; reserved bits fixed to zero
   logic [7:0] pair_a_img;
   logic [7:0] pair_b_img;
   logic [7:0] timer_img;
   logic [7:0] sd_img;

   assign pair_a_img = {1'b0, cfg_r[1], 1'b0, cfg_r[0]};
   assign pair_b_img = {1'b0, cfg_r[3], 1'b0, cfg_r[2]};
   assign timer_img = {1'b0, on_r, 1'b0, per_r};
   assign sd_img = {1'b0, ov_dis_r, uv_dis_r, recover_r, 4'h0};

   // Both faults are taken as levels: the cut lasts as long as the
   // fault, and what follows depends only on the stored settings.
   // Shutdown only where the matching disable bit is clear
   assign supply_cut = (supply_overvoltage && !ov_dis_r)
      || (supply_undervoltage && !uv_dis_r);

   ////////////////////////////////////////////////////////////////////////
   // Tick divider: one-cycle enable every 0.1 ms
   // One free-running divider keeps every timer on one time base; its
   // phase is not reset on a timer start, so the first on-time slice
   // after a start can be up to TICK_CNT-1 clocks short.
   logic [15:0] div_r;
   logic [15:0] div_nxt;
   logic tick;

   assign tick = (div_r == 16'(TICK_CNT - 1));

   always_comb
   begin
      div_nxt = tick ? 16'h0000 : div_r + 16'h0001;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         div_r <= 16'h0000;
      else
         div_r <= div_nxt;
   end

   ////////////////////////////////////////////////////////////////////////
   // Register next values
   always_comb
   begin
      for (int i = 0; i < 4; i++)
         cfg_nxt[i] = cfg_r[i];
      on_nxt = on_r;
      per_nxt = per_r;
      ov_dis_nxt = ov_dis_r;
      uv_dis_nxt = uv_dis_r;
      recover_nxt = recover_r;
      rd_nxt = rd_r;

      // Priority, lowest first: software write, supply fault, restart,
      // overload. The hardware clears come last so that a write in the
      // same cycle can never bring a faulted switch back on.
      // Software writes
      if (reg_wr_en)
      begin
         case (reg_addr)
            ADDR_PAIR_A:
            begin
               cfg_nxt[0] = reg_wr_data[PAIR_LO_LSB +: 3];
               cfg_nxt[1] = reg_wr_data[PAIR_HI_LSB +: 3];
            end
            ADDR_PAIR_B:
            begin
               cfg_nxt[2] = reg_wr_data[PAIR_LO_LSB +: 3];
               cfg_nxt[3] = reg_wr_data[PAIR_HI_LSB +: 3];
            end
            ADDR_SECOND_CYCLE_TIMER:
            begin
               on_nxt = reg_wr_data[TMR_ON_LSB +: 3];
               per_nxt = reg_wr_data[TMR_PER_LSB +: 3];
            end
            ADDR_SHUTDOWN:
            begin
               ov_dis_nxt = reg_wr_data[SD_OV_DIS_BIT];
               uv_dis_nxt = reg_wr_data[SD_UV_DIS_BIT];
               recover_nxt = reg_wr_data[SD_RECOVER_BIT];
            end
            default:
            begin
               // Unmapped address: write ignored
            end
         endcase
      end

      // Supply fault without recovery drops the settings for good
      if (supply_cut && !recover_r)
         for (int i = 0; i < 4; i++)
            cfg_nxt[i] = HSTC_SW_OFF;

      // Restart mode clears the switches, and the timer in cyclic sense
      if (chip_restart_state)
      begin
         for (int i = 0; i < 4; i++)
            cfg_nxt[i] = HSTC_SW_OFF;
         if (cyclic_sense_active)
         begin
            on_nxt = ON_STOP_LOW;
            per_nxt = RST_SECOND_CYCLE_TIMER[TMR_PER_LSB +: 3];
         end
      end

      // Overload is a level; the field stays clear after it drops
      // Overload clear beats a same-cycle software write
      for (int i = 0; i < 4; i++)
         if (switch_overload[i])
            cfg_nxt[i] = HSTC_SW_OFF;

      // Read data, captured on the read strobe
      if (reg_rd_en)
      begin
         case (reg_addr)
            ADDR_PAIR_A: rd_nxt = pair_a_img;
            ADDR_PAIR_B: rd_nxt = pair_b_img;
            ADDR_SECOND_CYCLE_TIMER: rd_nxt = timer_img;
            ADDR_SHUTDOWN: rd_nxt = sd_img & SD_WRITE_MASK;
            default: rd_nxt = 8'h00;
         endcase
      end
   end

   // Register flip-flops
   // Reset loads the package reset images; every switch field takes RST_PAIR
   // bits 2:0, so a change to the high field of RST_PAIR needs an edit here.
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         for (int i = 0; i < 4; i++)
            cfg_r[i] <= RST_PAIR[2:0];
         on_r <= RST_SECOND_CYCLE_TIMER[TMR_ON_LSB +: 3];
         per_r <= RST_SECOND_CYCLE_TIMER[TMR_PER_LSB +: 3];
         ov_dis_r <= RST_SHUTDOWN[SD_OV_DIS_BIT];
         uv_dis_r <= RST_SHUTDOWN[SD_UV_DIS_BIT];
         recover_r <= RST_SHUTDOWN[SD_RECOVER_BIT];
         rd_r <= 8'h00;
      end
      else
      begin
         for (int i = 0; i < 4; i++)
            cfg_r[i] <= cfg_nxt[i];
         on_r <= on_nxt;
         per_r <= per_nxt;
         ov_dis_r <= ov_dis_nxt;
         uv_dis_r <= uv_dis_nxt;
         recover_r <= recover_nxt;
         rd_r <= rd_nxt;
      end
   end

   assign reg_rd_data = rd_r;

   ////////////////////////////////////////////////////////////////////////
   // Second cycle timer
   // It counts only while some switch follows it; with no user the
   // count is held at zero, so the next start begins a fresh period.
   assign tmr2_assigned = (cfg_r[0] == HSTC_SW_TMR2)
      || (cfg_r[1] == HSTC_SW_TMR2) || (cfg_r[2] == HSTC_SW_TMR2)
      || (cfg_r[3] == HSTC_SW_TMR2);

   logic tmr2_level;

   // Same code tables serve the first timer outside
   hstc_cycle_timer u_second_cycle_timer (
      .clock(clock),
      .rst(rst),
      .tick(tick),
      .on_code(on_r),
      .per_code(per_r),
      .assigned(tmr2_assigned),
      .timer_out(tmr2_level)
   );

   assign second_cycle_timer = tmr2_level;

   ////////////////////////////////////////////////////////////////////////
   // Per-switch mode decode
   // Reserved codes 110 and 111 leave the switch off, the safe choice
   for (genvar g = 0; g < 4; g++)
   begin : g_sw
      always_comb
      begin
         case (cfg_r[g])
            HSTC_SW_ON: sw_level[g] = 1'b1;
            HSTC_SW_TMR1: sw_level[g] = first_cycle_timer;
            HSTC_SW_TMR2: sw_level[g] = tmr2_level;
            HSTC_SW_FIRST_DUTY_GENERATOR: sw_level[g] = first_duty_generator;
            HSTC_SW_SECOND_DUTY_GENERATOR: sw_level[g] = second_duty_generator;
            default: sw_level[g] = 1'b0; // Off and reserved codes
         endcase
      end
   end

   // The drive is registered so the switch drivers see glitch-free
   // levels; this costs one cycle after any configuration change, so
   // the output follows one cycle after the write edge.
   // Drive: forced low while a supply fault cuts; held settings come
   // back on their own once it clears when recovery is enabled
   always_comb
   begin
      sw_nxt = supply_cut ? 4'h0 : (sw_level & ~switch_overload);
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         sw_r <= 4'h0;
      else
         sw_r <= sw_nxt;
   end

   assign switch_output = sw_r;

endmodule : hstc_switch_ctrl
`default_nettype wire

// ==== include/hstc_pkg.sv ====
// Shared constants for the high-side switch and second timer control block
package hstc_pkg;

   // Register port widths
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;

   // Register addresses (7-bit register index)
   localparam logic [6:0] ADDR_SECOND_CYCLE_TIMER = 7'h0d;
   localparam logic [6:0] ADDR_SHUTDOWN = 7'h10;
   localparam logic [6:0] ADDR_PAIR_A = 7'h14;
   localparam logic [6:0] ADDR_PAIR_B = 7'h15;

   // Reset values
   localparam logic [7:0] RST_SECOND_CYCLE_TIMER = 8'h00;
   localparam logic [7:0] RST_SHUTDOWN = 8'h00;
   localparam logic [7:0] RST_PAIR = 8'h00;

   // Shutdown register field positions
   localparam int SD_OV_DIS_BIT = 6;
   localparam int SD_UV_DIS_BIT = 5;
   localparam int SD_RECOVER_BIT = 4;
   localparam logic [7:0] SD_WRITE_MASK = 8'h70;

   // Timer register field positions
   localparam int TMR_ON_LSB = 4;
   localparam int TMR_PER_LSB = 0;

   // Switch field positions in each pair register
   localparam int PAIR_LO_LSB = 0;
   localparam int PAIR_HI_LSB = 4;

   // Switch modes of a three-bit switch field
   typedef enum logic [2:0] {
      HSTC_SW_OFF = 3'h0,
      HSTC_SW_ON = 3'h1,
      HSTC_SW_TMR1 = 3'h2,
      HSTC_SW_TMR2 = 3'h3,
      HSTC_SW_FIRST_DUTY_GENERATOR = 3'h4,
      HSTC_SW_SECOND_DUTY_GENERATOR = 3'h5
   } hstc_mode_t;

   // On-time codes that stop the timer, and the reserved period code
   localparam logic [2:0] ON_STOP_LOW = 3'h0;
   localparam logic [2:0] ON_STOP_HIGH = 3'h6;
   localparam logic [2:0] ON_RESERVED = 3'h7;
   localparam logic [2:0] PER_RESERVED = 3'h7;

   // Time base: timer counts in ticks of 0.1 ms
   localparam int CLK_PERIOD_NS = 20;
   localparam int TICK_TIME_NS = 100000;
   localparam int TICK_CYCLES =
      (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Timer count width, in ticks (longest period 2 s = 20000 ticks)
   localparam int TCNT_W = 15;

   // On-time in ticks: 0.1, 0.3, 1.0, 10, 20 ms
   function automatic logic [14:0] hstc_on_ticks(input logic [2:0] code);
      case (code)
         3'h1: hstc_on_ticks = 15'h0001;
         3'h2: hstc_on_ticks = 15'h0003;
         3'h3: hstc_on_ticks = 15'h000a;
         3'h4: hstc_on_ticks = 15'h0064;
         3'h5: hstc_on_ticks = 15'h00c8;
         default: hstc_on_ticks = 15'h0000;
      endcase
   endfunction : hstc_on_ticks

   // Period in ticks: 10, 20, 50, 100, 200 ms, 1 s, 2 s
   function automatic logic [14:0] hstc_per_ticks(input logic [2:0] code);
      case (code)
         3'h0: hstc_per_ticks = 15'h0064;
         3'h1: hstc_per_ticks = 15'h00c8;
         3'h2: hstc_per_ticks = 15'h01f4;
         3'h3: hstc_per_ticks = 15'h03e8;
         3'h4: hstc_per_ticks = 15'h07d0;
         3'h5: hstc_per_ticks = 15'h2710;
         3'h6: hstc_per_ticks = 15'h4e20;
         default: hstc_per_ticks = 15'h4e20;
      endcase
   endfunction : hstc_per_ticks

endpackage : hstc_pkg

// ==== src/hstc_cycle_timer.sv ====
`timescale 1ns/10ps
`default_nettype none
// Cyclic timer: period and on-time counted in 0.1 ms ticks
module hstc_cycle_timer
   import hstc_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Time base
   input wire logic tick,
   // Configuration
   input wire logic [2:0] on_code,
   input wire logic [2:0] per_code,
   input wire logic assigned,
   // Timer level
   output logic timer_out
);
   import hstc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   logic [TCNT_W-1:0] cnt_r; // Ticks since start of period
   logic [TCNT_W-1:0] cnt_nxt;
   logic out_r; // Registered timer level
   logic out_nxt;
   logic running; // Timer counting
   logic [TCNT_W-1:0] on_ticks;
   logic [TCNT_W-1:0] per_ticks;

   assign on_ticks = hstc_on_ticks(on_code);
   assign per_ticks = hstc_per_ticks(per_code);
   // Only runs once assigned and given a real on-time
   assign running = assigned && (on_code != ON_STOP_LOW)
      && (on_code != ON_STOP_HIGH) && (on_code != ON_RESERVED);

   ////////////////////////////////////////////////////////////////////////
   // Next count and level
   always_comb
   begin
      cnt_nxt = cnt_r;
      out_nxt = out_r;
      if (!running)
      begin
         // Stopped: restart from the period's beginning next time
         cnt_nxt = '0;
         out_nxt = (on_code == ON_STOP_HIGH);
      end
      else
      begin
         // High for the on-time at the start of each period
         out_nxt = (cnt_r < on_ticks);
         if (tick)
         begin
            // Wrap at the period end; >= covers a shortened period
            if (cnt_r >= per_ticks - 15'h0001)
               cnt_nxt = '0;
            else
               cnt_nxt = cnt_r + 15'h0001;
         end
      end
   end

   // Registers
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         cnt_r <= '0;
         out_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         out_r <= out_nxt;
      end
   end

   assign timer_out = out_r;

endmodule : hstc_cycle_timer
`default_nettype wire

// ==== test/hstc_mcu_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Controller side of the register port; drives at falling edges
module hstc_mcu_model
   import hstc_pkg::*;
(
   // Clock
   input wire logic clock,
   // Register port toward the block
   output logic reg_wr_en,
   output logic reg_rd_en,
   output logic [ADDR_W-1:0] reg_addr,
   output logic [DATA_W-1:0] reg_wr_data,
   input wire logic [DATA_W-1:0] reg_rd_data
);
   import hstc_pkg::*;

   initial
   begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 7'h7f;
      reg_wr_data = 8'h00;
   end
   // One-cycle strobe; released lines show the inverted last value
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_wr_en = 1'b1;
      reg_addr = a;
      reg_wr_data = d;
      @(negedge clock);
      reg_wr_en = 1'b0;
      reg_addr = ~a;
      reg_wr_data = ~d;
   endtask : wr
   // Read data stands after the strobe edge, so take it a cycle later
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(negedge clock);
      reg_rd_en = 1'b1;
      reg_addr = a;
      @(negedge clock);
      reg_rd_en = 1'b0;
      reg_addr = ~a;
      @(negedge clock);
      d = reg_rd_data;
   endtask : rd
endmodule : hstc_mcu_model
`default_nettype wire

// ==== test/hstc_switch_ctrl_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
// Port checker of the switch control block
module hstc_switch_ctrl_chk
   import hstc_pkg::*;
#(
   parameter int TICK_CNT = TICK_CYCLES // Clocks per tick, as the design
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wr_data,
   input wire logic [DATA_W-1:0] reg_rd_data,
   input wire logic chip_restart_state,
   input wire logic cyclic_sense_active,
   input wire logic supply_overvoltage,
   input wire logic supply_undervoltage,
   input wire logic [3:0] switch_overload,
   input wire logic [3:0] switch_output,
   input wire logic second_cycle_timer
);
   import hstc_pkg::*;

   // Shadows of shutdown and timer registers; hardware clear wins
   logic [7:0] sd_r, sd_nxt, tm_r, tm_nxt;
   always_comb
   begin
      sd_nxt = sd_r;
      tm_nxt = tm_r;
      if (reg_wr_en && reg_addr == ADDR_SHUTDOWN)
         sd_nxt = reg_wr_data & SD_WRITE_MASK;
      if (reg_wr_en && reg_addr == ADDR_SECOND_CYCLE_TIMER)
         tm_nxt = reg_wr_data & 8'h77;
      if (chip_restart_state && cyclic_sense_active)
         tm_nxt = 8'h00;
   end
   always_ff @(posedge clock)
   begin
      sd_r <= rst ? 8'h00 : sd_nxt;
      tm_r <= rst ? 8'h00 : tm_nxt;
   end
   ////////////////////////////////////////
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   property p_rsv;
      reg_rd_data[7] == 1'b0 && reg_rd_data[3] == 1'b0;
   endproperty
   a_rsv: assert property (p_rsv)
      else $error("reserved bit read high");
   property p_sd_rsv;
      reg_rd_en && reg_addr == ADDR_SHUTDOWN |=> reg_rd_data[3:0] == 4'h0;
   endproperty
   a_sd_rsv: assert property (p_sd_rsv)
      else $error("shutdown low bits read high");
   property p_ov;
      supply_overvoltage && !sd_r[SD_OV_DIS_BIT] |=> switch_output == 4'h0;
   endproperty
   a_ov: assert property (p_ov)
      else $error("switch on during overvoltage");
   property p_uv;
      supply_undervoltage && !sd_r[SD_UV_DIS_BIT] |=> switch_output == 4'h0;
   endproperty
   a_uv: assert property (p_uv)
      else $error("switch on during undervoltage");
   property p_ovl;
      |switch_overload |=> (switch_output & $past(switch_overload)) == 4'h0;
   endproperty
   a_ovl: assert property (p_ovl)
      else $error("overloaded switch still on");
   property p_rst;
      chip_restart_state |-> ##2 switch_output == 4'h0;
   endproperty
   a_rst: assert property (p_rst)
      else $error("switch on after restart");
   property p_on0;
      (tm_r[6:4] == ON_STOP_LOW) [*3] |-> !second_cycle_timer;
   endproperty
   a_on0: assert property (p_on0)
      else $error("stopped timer not low");
   property p_on6;
      (tm_r[6:4] == ON_STOP_HIGH) [*3] |-> second_cycle_timer;
   endproperty
   a_on6: assert property (p_on6)
      else $error("stopped timer not high");
   property p_off;
      reg_wr_en && reg_addr == ADDR_PAIR_B && reg_wr_data[6:4] == 3'h0
         |-> ##2 !switch_output[3];
   endproperty
   a_off: assert property (p_off)
      else $error("switch four on after off code");
   // Main scenarios reached
   c_ov: cover property (supply_overvoltage && !sd_r[SD_OV_DIS_BIT]);
   c_run: cover property ($rose(second_cycle_timer));
   c_rst: cover property (chip_restart_state && cyclic_sense_active);
endmodule : hstc_switch_ctrl_chk
bind hstc_switch_ctrl hstc_switch_ctrl_chk #(.TICK_CNT(TICK_CNT)) u_chk (
   .clock, .rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data,
   .reg_rd_data, .chip_restart_state, .cyclic_sense_active,
   .supply_overvoltage, .supply_undervoltage, .switch_overload,
   .switch_output, .second_cycle_timer);
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench of the switch control block
module tb_top;
   import hstc_pkg::*;
   localparam int TK = 1; // Tick per clock keeps the 2 s period short
   // On-times and periods of each code, in 0.1 ms ticks
   localparam int ON_T [5] = '{1, 3, 10, 100, 200};
   localparam int PER_T [7] = '{100, 200, 500, 1000, 2000, 10000, 20000};
   localparam logic [6:0] AD [4] = '{ADDR_SECOND_CYCLE_TIMER, ADDR_SHUTDOWN,
      ADDR_PAIR_A, ADDR_PAIR_B};
   localparam logic [7:0] MK [4] = '{8'h77, 8'h70, 8'h77, 8'h77};
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic ft = 1'b0, d1 = 1'b0, d2 = 1'b0, rs = 1'b0, cy = 1'b0;
   logic ov = 1'b0, uv = 1'b0;
   logic [3:0] ol = 4'h0;
   logic reg_wr_en, reg_rd_en;
   logic [6:0] reg_addr;
   logic [7:0] reg_wr_data, reg_rd_data;
   logic [3:0] so;
   logic st;
   int n_errors = 0, checked = 0;
   always #10 clock = ~clock;
   hstc_mcu_model mcu (.clock, .reg_wr_en, .reg_rd_en, .reg_addr,
      .reg_wr_data, .reg_rd_data);
   hstc_switch_ctrl #(.TICK_CNT(TK)) dut (.clock, .rst, .reg_wr_en,
      .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data,
      .first_cycle_timer(ft), .first_duty_generator(d1),
      .second_duty_generator(d2), .chip_restart_state(rs),
      .cyclic_sense_active(cy), .supply_overvoltage(ov),
      .supply_undervoltage(uv), .switch_overload(ol),
      .switch_output(so), .second_cycle_timer(st));
   ////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask : tick
   task automatic chk(input string s, input logic [15:0] e,
      input logic [15:0] g);
      checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic rc(input logic [6:0] a, input logic [7:0] e,
      input string s);
      logic [7:0] d;
      mcu.rd(a, d);
      chk(s, e, d);
   endtask : rc
   // Counts high and whole-period length of the timer level
   task automatic meas(output int h, output int p);
      int n;
      for (n = 0; n < 50000 && st !== 1'b1; n++) @(negedge clock);
      for (h = 0; h < 50000 && st === 1'b1; h++) @(negedge clock);
      for (p = h; p < 50000 && st !== 1'b1; p++) @(negedge clock);
   endtask : meas
   ////////////////////////////////////////
   task automatic t_regs;
      for (int i = 0; i < 4; i++)
      begin
         rc(AD[i], 8'h00, "reset value");
         mcu.wr(AD[i], 8'hff);
         rc(AD[i], MK[i], "write mask");
         mcu.wr(AD[i], 8'h00);
      end
      mcu.wr(7'h20, 8'h5a);
      rc(7'h20, 8'h00, "unmapped");
   endtask : t_regs
   // Switch codes 0 to 5 on switches one and four, two source patterns
   task automatic t_modes;
      logic [5:0] v;
      for (int p = 0; p < 2; p++)
         for (int c = 0; c < 6; c++)
         begin
            {ft, d1, d2} = p ? 3'b010 : 3'b101;
            mcu.wr(ADDR_PAIR_A, {5'h00, c[2:0]});
            mcu.wr(ADDR_PAIR_B, {1'b0, c[2:0], 4'h0});
            tick(3);
            v = {d2, d1, 1'b0, ft, 1'b1, 1'b0};
            chk("switch one", v[c], so[0]);
            chk("switch four", v[c], so[3]);
         end
      mcu.wr(ADDR_PAIR_A, 8'h00);
      mcu.wr(ADDR_PAIR_B, 8'h00);
   endtask : t_modes
   task automatic t_timer;
      int h, p;
      mcu.wr(ADDR_PAIR_A, 8'h30); // Timer assigned first
      mcu.wr(ADDR_SECOND_CYCLE_TIMER, 8'h60);
      tick(4);
      chk("stop high", 2'b11, {st, so[1]});
      mcu.wr(ADDR_SECOND_CYCLE_TIMER, 8'h00);
      tick(4);
      chk("stop low", 2'b00, {st, so[1]});
      for (int i = 0; i < 2; i++)
      begin
         mcu.wr(ADDR_SECOND_CYCLE_TIMER, i ? 8'h21 : 8'h10);
         meas(h, p);
         meas(h, p);
         chk("on time", 16'(ON_T[i] * TK), 16'(h));
         chk("period", 16'(PER_T[i] * TK), 16'(p));
      end
      mcu.wr(ADDR_SECOND_CYCLE_TIMER, 8'h00);
      mcu.wr(ADDR_PAIR_A, 8'h00);
   endtask : t_timer
   // On-time codes 1 to 5 and period codes 0 to 6, timed from a fresh start
   task automatic t_codes;
      int h, p;
      logic [2:0] oc;
      mcu.wr(ADDR_PAIR_A, 8'h30); // Timer assigned first
      for (int j = 0; j < 7; j++)
      begin
         oc = 3'((j % 5) + 1);
         mcu.wr(ADDR_SECOND_CYCLE_TIMER, {1'b0, oc, 1'b0, 3'(j)});
         meas(h, p);
         chk("code on time", 16'(ON_T[j % 5] * TK), 16'(h));
         chk("code period", 16'(PER_T[j] * TK), 16'(p));
         mcu.wr(ADDR_SECOND_CYCLE_TIMER, 8'h00);
      end
      mcu.wr(ADDR_PAIR_A, 8'h00);
   endtask : t_codes
   task automatic t_supply;
      mcu.wr(ADDR_PAIR_A, 8'h01);
      ov = 1'b1;
      tick(2);
      chk("ov cut", 1'b0, so[0]);
      ov = 1'b0;
      tick(3);
      chk("no recovery", 1'b0, so[0]);
      rc(ADDR_PAIR_A, 8'h00, "field lost");
      mcu.wr(ADDR_SHUTDOWN, 8'h10);
      mcu.wr(ADDR_PAIR_A, 8'h01);
      uv = 1'b1;
      tick(2);
      chk("uv cut", 1'b0, so[0]);
      uv = 1'b0;
      tick(3);
      chk("recovery", 1'b1, so[0]);
      mcu.wr(ADDR_SHUTDOWN, 8'h60);
      {ov, uv} = 2'b11;
      tick(3);
      chk("cut disabled", 1'b1, so[0]);
      {ov, uv} = 2'b00;
      mcu.wr(ADDR_SHUTDOWN, 8'h00);
   endtask : t_supply
   task automatic t_overload;
      mcu.wr(ADDR_PAIR_B, 8'h11);
      ol = 4'h4;
      tick(2);
      ol = 4'h0;
      chk("overload", 2'b10, so[3:2]);
      rc(ADDR_PAIR_B, 8'h10, "overload field");
      mcu.wr(ADDR_PAIR_B, 8'h00);
   endtask : t_overload
   // Restart with and without cyclic sensing
   task automatic t_restart;
      for (int c = 0; c < 2; c++)
      begin
         mcu.wr(ADDR_SECOND_CYCLE_TIMER, 8'h21);
         mcu.wr(ADDR_PAIR_A, 8'h31);
         {cy, rs} = {c[0], 1'b1};
         tick(1);
         {cy, rs} = 2'b00;
         rc(ADDR_PAIR_A, 8'h00, "restart switch");
         rc(ADDR_SECOND_CYCLE_TIMER, c ? 8'h00 : 8'h21, "restart timer");
      end
   endtask : t_restart
   task test_done;
      if (n_errors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : test_done
   ////////////////////////////////////////
   initial
   begin
      tick(6);
      rst = 1'b0;
      t_regs;
      t_modes;
      t_timer;
      t_codes;
      t_supply;
      t_overload;
      t_restart;
      test_done;
   end
   // Hang guard, well above the some 35000 cycles the run needs
   initial
   begin
      #1000000;
      n_errors++;
      test_done;
   end
endmodule : tb_top
`default_nettype wire
